// ==== ssc_defines.svh ====
/*
 Register offsets, reset values, field positions and timing counts
 of the speed setpoint channel. Assumes a 100 MHz clock.
*/
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// Byte offsets on APB
`define SSC_OFS_MODE 12'h000
`define SSC_OFS_MAIN_SRC 12'h004
`define SSC_OFS_ADD_SRC 12'h008
`define SSC_OFS_SEL_SRC 12'h00C
`define SSC_OFS_CMD_SRC 12'h010
`define SSC_OFS_MIN 12'h014
`define SSC_OFS_MAX 12'h018
`define SSC_OFS_POS_LIM 12'h01C
`define SSC_OFS_NEG_LIM 12'h020
`define SSC_OFS_UP_MS 12'h024
`define SSC_OFS_DOWN_MS 12'h028
`define SSC_OFS_QS_MS 12'h02C
`define SSC_OFS_STATUS 12'h030
`define SSC_OFS_RAMP 12'h034
`define SSC_OFS_TARGET 12'h038
`define SSC_OFS_FIXED_BASE 12'h040
`define SSC_FIXED_PAGE 6'h01

// Setpoint source code that selects the fixed speeds
`define SSC_SRC_FIXED 16'h0400

// Binary signal source kinds
`define SSC_KIND_ZERO 2'h0
`define SSC_KIND_ONE 2'h1
`define SSC_KIND_DI 2'h2
`define SSC_KIND_FB 2'h3
`define SSC_SRC_W 6

// Field positions in the command source register
`define SSC_CMD_RUN 0
`define SSC_CMD_INV 6
`define SSC_CMD_NEG 12
`define SSC_CMD_POS 18
`define SSC_CMD_QS 24

// Mode register
`define SSC_MODE_DIRECT 1'h1

// Reset values
`define SSC_RST_MODE 1'h1
`define SSC_RST_SRC 16'h0000
`define SSC_RST_SEL 24'h000000
`define SSC_RST_CMD 30'h00000000
`define SSC_RST_MIN 32'h00000000
`define SSC_RST_MAX 32'h000005DC
`define SSC_RST_POS_LIM 32'h00033450
`define SSC_RST_NEG_LIM 32'hFFFCCBB0
`define SSC_RST_UP_MS 32'h00002710
`define SSC_RST_DOWN_MS 32'h00002710
`define SSC_RST_QS_MS 32'h00000000

// Timing
`define SSC_CLK_PERIOD_NS 10
`define SSC_TIME_UNIT_NS 1000000
`define SSC_CYCLES_PER_MS (`SSC_TIME_UNIT_NS / `SSC_CLK_PERIOD_NS)

`endif

// ==== ssc_pkg.sv ====
/*
 Types of the speed setpoint channel.
 Assumes ssc_defines.svh for all numeric constants.
*/
package ssc_pkg;

    typedef struct packed {
        logic [1:0] kind;
        logic [3:0] index;
    } ssc_src_type;

    typedef struct packed {
        logic settled;
        logic quick_stop;
        logic pos_inhibit;
        logic neg_inhibit;
        logic invert;
        logic run;
        logic overspeed;
    } ssc_flags_type;

    typedef enum logic [1:0] {
        RAMP_HOLD,
        RAMP_AWAY,
        RAMP_TOWARD
    } ssc_ramp_type;

endpackage

// ==== ssc_speed_setpoint_channel.sv ====
/*
 Speed setpoint channel: fixed speeds, inversion, direction inhibit,
 min/max limiting and ramp-function generator, with APB registers.
 Assumes a 100 MHz clk, synchronous active-low nrst, a fieldbus
 control word and actual speed from logic on the same clock.
*/
// Chosen here: the APB interface to the registers and the address map.
// Operation
// - Sixteen fixed speeds; select bits come from discrete inputs or fieldbus.
// - Main or additional setpoint takes fixed speeds when its source is 1024.
// - Direct mode sums the four fixed values whose select bits are set.
// - Binary mode uses four select bits to index one of sixteen values.
// - Mode value 1 selects direct selection.
// - Select bit 0 enables value one, bit 1 value two; sources configurable.
// - Inversion signal 1 negates the setpoint, 0 passes it.
// - Inversion may come from fieldbus control word bit 11.
// - After reset both directions of rotation are allowed.
// - Inhibit set to 1 blocks its direction, 0 allows it.
// - Inhibit from a binary input blocks negative while input is 1.
// - No steady running below minimum speed; only passed while ramping.
// - Maximum speed, default 1500 rpm, bounds magnitude both directions.
// - Alarm whenever actual speed exceeds the maximum speed.
// - Per-direction limits, defaults 210000 and -210000 rpm, also clamp.
// - Ramp generator limits setpoint rate when accelerating and braking.
// - Maximum speed scales the ramp slope.
// - Ramp-up time, default 10 s, spans zero to maximum speed.
// - Ramp-down time, default 10 s, spans maximum speed to standstill.
// - Quick stop uses its own ramp-down time, default 0 s.
`include "ssc_defines.svh"

module ssc_speed_setpoint_channel
    import ssc_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = `SSC_CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control sources
    input wire logic [15:0] discrete_input,
    input wire logic [15:0] fieldbus_ctrl_word,
    input wire logic signed [31:0] actual_speed,
    // Results
    output logic signed [31:0] speed_setpoint,
    output ssc_flags_type status_flags
);

    function automatic logic src_level(input ssc_src_type s,
                                       input logic [15:0] di,
                                       input logic [15:0] cw);
        logic v;
        v = 1'b0;
        case (s.kind)
            `SSC_KIND_ONE: v = 1'b1;
            `SSC_KIND_DI: v = di[s.index];
            `SSC_KIND_FB: v = cw[s.index];
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    function automatic logic [31:0] abs32(input logic signed [31:0] x);
        return x[31] ? 32'(-x) : 32'(x);
    endfunction

    // Configuration registers
    logic mode_reg;
    logic [15:0] main_src_reg;
    logic [15:0] add_src_reg;
    logic [23:0] sel_src_reg;
    logic [29:0] cmd_src_reg;
    logic [31:0] min_reg;
    logic [31:0] max_reg;
    logic signed [31:0] pos_lim_reg;
    logic signed [31:0] neg_lim_reg;
    logic [31:0] up_ms_reg;
    logic [31:0] down_ms_reg;
    logic [31:0] qs_ms_reg;
    logic signed [31:0] fixed_reg [0:15];

    // Bus state
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;

    // Discrete input synchroniser
    logic [15:0] di_s1_reg;
    logic [15:0] di_s2_reg;
    logic [15:0] di_s3_reg;
    logic [15:0] di_reg;
    logic [15:0] di_next;

    // Ramp state
    logic signed [31:0] ramp_reg;
    logic signed [31:0] ramp_next;
    logic [47:0] acc_reg;
    logic [47:0] acc_next;
    logic signed [31:0] target;
    ssc_flags_type flags_reg;

    // Bus decode
    wire logic access = psel & penable;
    wire logic first_cycle = access & ~ack_reg;
    wire logic wr_en = access & ack_reg & pwrite & ~err_reg;
    wire logic fixed_hit = (paddr[11:6] == `SSC_FIXED_PAGE);
    wire logic [3:0] fixed_idx = paddr[5:2];
    logic reg_hit;
    logic [31:0] rd_mux;

    always_comb begin
        reg_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            `SSC_OFS_MODE: rd_mux = {31'h00000000, mode_reg};
            `SSC_OFS_MAIN_SRC: rd_mux = {16'h0000, main_src_reg};
            `SSC_OFS_ADD_SRC: rd_mux = {16'h0000, add_src_reg};
            `SSC_OFS_SEL_SRC: rd_mux = {8'h00, sel_src_reg};
            `SSC_OFS_CMD_SRC: rd_mux = {2'h0, cmd_src_reg};
            `SSC_OFS_MIN: rd_mux = min_reg;
            `SSC_OFS_MAX: rd_mux = max_reg;
            `SSC_OFS_POS_LIM: rd_mux = pos_lim_reg;
            `SSC_OFS_NEG_LIM: rd_mux = neg_lim_reg;
            `SSC_OFS_UP_MS: rd_mux = up_ms_reg;
            `SSC_OFS_DOWN_MS: rd_mux = down_ms_reg;
            `SSC_OFS_QS_MS: rd_mux = qs_ms_reg;
            `SSC_OFS_STATUS: rd_mux = {25'h0000000, flags_reg};
            `SSC_OFS_RAMP: rd_mux = ramp_reg;
            `SSC_OFS_TARGET: rd_mux = target;
            default: begin
                reg_hit = fixed_hit & (paddr[1:0] == 2'h0);
                rd_mux = reg_hit ? fixed_reg[fixed_idx] : 32'h00000000;
            end
        endcase
    end

    // One wait state so read data leaves a flip-flop
    assign pready = ack_reg;
    assign pslverr = ack_reg & err_reg;
    assign prdata = rdata_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= first_cycle;
            if (first_cycle) begin
                err_reg <= ~reg_hit;
                rdata_reg <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    // Read-only locations ignore writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode_reg <= `SSC_RST_MODE;
            main_src_reg <= `SSC_RST_SRC;
            add_src_reg <= `SSC_RST_SRC;
            sel_src_reg <= `SSC_RST_SEL;
            cmd_src_reg <= `SSC_RST_CMD;
            min_reg <= `SSC_RST_MIN;
            max_reg <= `SSC_RST_MAX;
            pos_lim_reg <= `SSC_RST_POS_LIM;
            neg_lim_reg <= `SSC_RST_NEG_LIM;
            up_ms_reg <= `SSC_RST_UP_MS;
            down_ms_reg <= `SSC_RST_DOWN_MS;
            qs_ms_reg <= `SSC_RST_QS_MS;
            for (int i = 0; i < 16; i++) begin
                fixed_reg[i] <= 32'h00000000;
            end
        end else if (wr_en) begin
            case (paddr)
                `SSC_OFS_MODE: mode_reg <= pwdata[0];
                `SSC_OFS_MAIN_SRC: main_src_reg <= pwdata[15:0];
                `SSC_OFS_ADD_SRC: add_src_reg <= pwdata[15:0];
                `SSC_OFS_SEL_SRC: sel_src_reg <= pwdata[23:0];
                `SSC_OFS_CMD_SRC: cmd_src_reg <= pwdata[29:0];
                `SSC_OFS_MIN: min_reg <= pwdata;
                `SSC_OFS_MAX: max_reg <= pwdata;
                `SSC_OFS_POS_LIM: pos_lim_reg <= pwdata;
                `SSC_OFS_NEG_LIM: neg_lim_reg <= pwdata;
                `SSC_OFS_UP_MS: up_ms_reg <= pwdata;
                `SSC_OFS_DOWN_MS: down_ms_reg <= pwdata;
                `SSC_OFS_QS_MS: qs_ms_reg <= pwdata;
                default: begin
                    if (fixed_hit) begin
                        fixed_reg[fixed_idx] <= pwdata;
                    end
                end
            endcase
        end
    end

    // A bit moves only when stages two and three agree
    assign di_next = (di_s2_reg & ~(di_s2_reg ^ di_s3_reg))
                   | (di_reg & (di_s2_reg ^ di_s3_reg));

    always_ff @(posedge clk) begin
        if (!nrst) begin
            di_s1_reg <= 16'h0000;
            di_s2_reg <= 16'h0000;
            di_s3_reg <= 16'h0000;
            di_reg <= 16'h0000;
        end else begin
            di_s1_reg <= discrete_input;
            di_s2_reg <= di_s1_reg;
            di_s3_reg <= di_s2_reg;
            di_reg <= di_next;
        end
    end

    // Fixed speed selection
    logic [3:0] sel_bits;
    logic signed [31:0] direct_term [0:3];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : sel_gen
            assign sel_bits[g] = src_level(sel_src_reg[6*g +: 6], di_reg,
                                           fieldbus_ctrl_word);
            assign direct_term[g] = sel_bits[g] ? fixed_reg[g] : 32'sh0;
        end
    endgenerate

    // Sum wraps at 32 bits; values are expected to stay well inside
    wire logic signed [31:0] direct_sum = direct_term[0] + direct_term[1]
                                        + direct_term[2] + direct_term[3];
    wire logic signed [31:0] binary_val = fixed_reg[sel_bits];
    wire logic signed [31:0] fixed_out =
        (mode_reg == `SSC_MODE_DIRECT) ? direct_sum : binary_val;

    // Other setpoint sources are not part of this block and read as zero
    wire logic signed [31:0] main_val =
        (main_src_reg == `SSC_SRC_FIXED) ? fixed_out : 32'sh0;
    wire logic signed [31:0] add_val =
        (add_src_reg == `SSC_SRC_FIXED) ? fixed_out : 32'sh0;
    wire logic signed [31:0] total = main_val + add_val;

    // Command signals
    wire logic run_on = src_level(cmd_src_reg[`SSC_CMD_RUN +: 6], di_reg,
                                  fieldbus_ctrl_word);
    wire logic invert_on = src_level(cmd_src_reg[`SSC_CMD_INV +: 6], di_reg,
                                     fieldbus_ctrl_word);
    wire logic neg_inh = src_level(cmd_src_reg[`SSC_CMD_NEG +: 6], di_reg,
                                   fieldbus_ctrl_word);
    wire logic pos_inh = src_level(cmd_src_reg[`SSC_CMD_POS +: 6], di_reg,
                                   fieldbus_ctrl_word);
    wire logic qs_on = src_level(cmd_src_reg[`SSC_CMD_QS +: 6], di_reg,
                                 fieldbus_ctrl_word);

    // Setpoint processing chain
    wire logic signed [31:0] inv_val = invert_on ? 32'(-total) : total;
    wire logic blocked = (neg_inh & inv_val[31])
                       | (pos_inh & ~inv_val[31] & (inv_val != 32'sh0));
    wire logic signed [31:0] dir_val = blocked ? 32'sh0 : inv_val;

    // Below minimum: push out to the minimum on an allowed side
    wire logic below_min = abs32(dir_val) < min_reg;
    wire logic go_neg = dir_val[31] | ((dir_val == 32'sh0) & pos_inh);
    wire logic both_inh = neg_inh & pos_inh;
    wire logic signed [31:0] min_val =
        ~below_min ? dir_val :
        both_inh ? 32'sh0 :
        go_neg ? 32'(-$signed(min_reg)) : $signed(min_reg);

    wire logic signed [31:0] max_pos = $signed(max_reg);
    wire logic signed [31:0] max_neg = 32'(-$signed(max_reg));
    wire logic signed [31:0] hi_lim =
        (max_pos < pos_lim_reg) ? max_pos : pos_lim_reg;
    wire logic signed [31:0] lo_lim =
        (max_neg > neg_lim_reg) ? max_neg : neg_lim_reg;
    wire logic signed [31:0] lim_val =
        (min_val > hi_lim) ? hi_lim :
        (min_val < lo_lim) ? lo_lim : min_val;

    assign target = (run_on & ~qs_on) ? lim_val : 32'sh0;

    // Ramp generator: one rpm step whenever the slope accumulator
    // passes the span; fast enough for any real ramp at one rpm/cycle
    ssc_ramp_type ramp_dir;
    logic [31:0] time_ms;
    logic [47:0] span;
    logic [47:0] acc_sum;

    always_comb begin
        if (ramp_reg == target) begin
            ramp_dir = RAMP_HOLD;
        end else if ((target > ramp_reg) ? ~ramp_reg[31] :
                     (ramp_reg[31] | (ramp_reg == 32'sh0))) begin
            ramp_dir = RAMP_AWAY;
        end else begin
            ramp_dir = RAMP_TOWARD;
        end
    end

    always_comb begin
        case (ramp_dir)
            RAMP_AWAY: time_ms = up_ms_reg;
            RAMP_TOWARD: time_ms = qs_on ? qs_ms_reg : down_ms_reg;
            default: time_ms = down_ms_reg;
        endcase
    end

    assign span = 48'(time_ms) * 48'(CYCLES_PER_MS);
    assign acc_sum = acc_reg + 48'(max_reg);

    always_comb begin
        ramp_next = ramp_reg;
        acc_next = 48'h000000000000;
        if (ramp_dir != RAMP_HOLD) begin
            if (span == 48'h000000000000) begin
                ramp_next = target;
            end else if (acc_sum >= span) begin
                ramp_next = (target > ramp_reg) ? 32'(ramp_reg + 32'sh1)
                                                : 32'(ramp_reg - 32'sh1);
                acc_next = (acc_sum - span >= span) ? 48'(span - 48'h1)
                                                    : 48'(acc_sum - span);
            end else begin
                acc_next = acc_sum;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ramp_reg <= 32'sh0;
            acc_reg <= 48'h000000000000;
        end else begin
            ramp_reg <= ramp_next;
            acc_reg <= acc_next;
        end
    end

    // Overspeed alarm and status
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= '{settled: ramp_next == target, quick_stop: qs_on,
                           pos_inhibit: pos_inh, neg_inhibit: neg_inh,
                           invert: invert_on, run: run_on,
                           overspeed: abs32(actual_speed) > max_reg};
        end
    end

    assign speed_setpoint = ramp_reg;
    assign status_flags = flags_reg;

endmodule

// ==== ssc_speed_setpoint_channel_monitor.sv ====
/*
 Checker bound to the speed setpoint channel.
 Assumes one APB master and the reset limits until written.
*/
`include "ssc_defines.svh"

module ssc_speed_setpoint_channel_monitor
    import ssc_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = `SSC_CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Controls
    input wire logic [15:0] discrete_input,
    input wire logic [15:0] fieldbus_ctrl_word,
    input wire logic signed [31:0] actual_speed,
    // Results
    input wire logic signed [31:0] speed_setpoint,
    input wire ssc_flags_type status_flags
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow limits; zero ramp times allow jumps
    logic [31:0] max_reg;
    logic up_zero_reg;
    logic dn_zero_reg;
    wire wr = psel && penable && pready && pwrite && !pslverr;
    wire [31:0] act_mag = actual_speed[31] ? -actual_speed : actual_speed;
    wire [31:0] sp_mag = speed_setpoint[31] ? -speed_setpoint : speed_setpoint;
    wire fast = up_zero_reg || dn_zero_reg;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            max_reg <= `SSC_RST_MAX;
            up_zero_reg <= 1'b0;
            dn_zero_reg <= 1'b0;
        end else if (wr) begin
            if (paddr == `SSC_OFS_MAX) max_reg <= pwdata;
            if (paddr == `SSC_OFS_UP_MS) up_zero_reg <= pwdata == 32'h0;
            if (paddr == `SSC_OFS_DOWN_MS) dn_zero_reg <= pwdata == 32'h0;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_one_wait;
        s_setup ##1 s_access |-> !pready ##1 pready;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("APB answer off");
    property p_over_on;
        act_mag > max_reg |=> status_flags.overspeed;
    endproperty
    a_over_on: assert property (p_over_on) else $error("alarm missing");
    property p_over_off;
        act_mag <= max_reg |=> !status_flags.overspeed;
    endproperty
    a_over_off: assert property (p_over_off) else $error("false alarm");
    property p_ramp_rate;
        !status_flags.quick_stop && !$past(fast) |->
            speed_setpoint - $past(speed_setpoint) <= 32'sh1 &&
            $past(speed_setpoint) - speed_setpoint <= 32'sh1;
    endproperty
    a_ramp_rate: assert property (p_ramp_rate) else $error("ramp too steep");
    property p_stop_decay;
        !status_flags.run |-> sp_mag <= $past(sp_mag);
    endproperty
    a_stop_decay: assert property (p_stop_decay) else $error("speed rose");
    property p_pos_block;
        status_flags.pos_inhibit |-> speed_setpoint <= 0 || speed_setpoint <= $past(speed_setpoint);
    endproperty
    a_pos_block: assert property (p_pos_block) else $error("positive run");
    property p_neg_block;
        status_flags.neg_inhibit |-> speed_setpoint >= 0 || speed_setpoint >= $past(speed_setpoint);
    endproperty
    a_neg_block: assert property (p_neg_block) else $error("negative run");
    property p_over_max;
        sp_mag > max_reg |=> sp_mag <= $past(sp_mag);
    endproperty
    a_over_max: assert property (p_over_max) else $error("above max");
endmodule

bind ssc_speed_setpoint_channel ssc_speed_setpoint_channel_monitor #(
    .CYCLES_PER_MS(CYCLES_PER_MS)
) i_mon (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .discrete_input, .fieldbus_ctrl_word, .actual_speed, .speed_setpoint,
    .status_flags);

// ==== ssc_ctrl_model.sv ====
/*
 Controller model: discrete inputs, fieldbus word, measured speed.
 Assumes the bench asks for levels on the same clock.
*/
module ssc_ctrl_model (
    // Clock
    input wire logic clk,
    // Levels asked for
    input wire logic [15:0] di_want,
    input wire logic [15:0] cw_want,
    input wire logic signed [31:0] spd_want,
    // Toward the channel
    output logic [15:0] discrete_input,
    output logic [15:0] fieldbus_ctrl_word,
    output logic signed [31:0] actual_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        discrete_input = 16'h0;
        fieldbus_ctrl_word = 16'h0;
        actual_speed = 32'sh0;
    end
    // Moves only just after an edge, like a real output stage
    always @(posedge clk) begin
        discrete_input <= di_want;
        fieldbus_ctrl_word <= cw_want;
        actual_speed <= spd_want;
    end
endmodule

// ==== ssc_speed_setpoint_channel_tb.sv ====
/*
 Bench for the speed setpoint channel: APB tasks and scenarios.
 Assumes the controller model and the bound checker.
*/
`include "ssc_defines.svh"

module ssc_speed_setpoint_channel_tb
    import ssc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic nrst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] di_want;
    logic [15:0] cw_want;
    logic signed [31:0] spd_want;
    logic [15:0] discrete_input;
    logic [15:0] fieldbus_ctrl_word;
    logic signed [31:0] actual_speed;
    logic signed [31:0] speed_setpoint;
    ssc_flags_type status_flags;
    logic [31:0] rd;
    logic err;
    int error_cnt;
    int n_checks;
    int n;
    logic [43:0] rst_tab [12] = '{{`SSC_OFS_MODE, 32'h1}, {`SSC_OFS_MAX, 32'h5DC},
        {`SSC_OFS_POS_LIM, 32'h33450}, {`SSC_OFS_NEG_LIM, 32'hFFFCCBB0},
        {`SSC_OFS_UP_MS, 32'h2710}, {`SSC_OFS_DOWN_MS, 32'h2710}, {`SSC_OFS_QS_MS, 32'h0},
        {`SSC_OFS_MIN, 32'h0}, {`SSC_OFS_CMD_SRC, 32'h0}, {`SSC_OFS_SEL_SRC, 32'h0},
        {`SSC_OFS_STATUS, 32'h40}, {`SSC_OFS_RAMP, 32'h0}};
    // Short millisecond keeps ramps of a few thousand cycles
    ssc_speed_setpoint_channel #(.CYCLES_PER_MS(10)) i_dut (.clk, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .discrete_input,
        .fieldbus_ctrl_word, .actual_speed, .speed_setpoint, .status_flags);
    ssc_ctrl_model i_ctrl (.clk, .di_want, .cw_want, .spd_want, .discrete_input,
        .fieldbus_ctrl_word, .actual_speed);
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_up(input string name);
        error_cnt++;
        $display("BAD %s expected answer seen timeout", name);
        final_report();
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) give_up("pready");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, rd, err);
        check("wr err", {31'h0, err}, 32'h0);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, rd, err);
        check($sformatf("reg %h", a), rd, exp);
    endtask
    task automatic drive(input logic [15:0] di, input logic [15:0] cw, input logic [31:0] sp);
        @(posedge clk);
        di_want <= di;
        cw_want <= cw;
        spd_want <= sp;
    endtask
    task automatic wait_speed(input logic signed [31:0] exp, input int limit);
        n = 0;
        while (speed_setpoint !== exp && n < limit) begin
            @(posedge clk);
            n++;
        end
        if (speed_setpoint !== exp) give_up("speed");
        check("speed", speed_setpoint, exp);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        {di_want, cw_want, spd_want} = '0;
        error_cnt = 0;
        n_checks = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        foreach (rst_tab[i]) rd_chk(rst_tab[i][43:32], rst_tab[i][31:0]);
        apb(12'h03C, 1'b1, 32'h1, rd, err);
        check("unmapped", {31'h0, err}, 32'h1);
        apb(12'h002, 1'b0, 32'h0, rd, err);
        check("misaligned", {rd[30:0], err}, 32'h1);
        wr(`SSC_OFS_FIXED_BASE, 32'h12C);
        wr(`SSC_OFS_FIXED_BASE + 12'h4, 32'h7D0);
        wr(`SSC_OFS_MAIN_SRC, 32'h400);
        wr(`SSC_OFS_SEL_SRC, 32'h860);
        wr(`SSC_OFS_CMD_SRC, 32'h20);
        wr(`SSC_OFS_UP_MS, 32'h3E8);
        drive(16'h1, 16'h0, 32'sh0);
        wait_speed(32'sh12C, 2200);
        check("ramp time", {31'h0, n > 1990 && n < 2020}, 32'h1);
        wr(`SSC_OFS_UP_MS, 32'h1);
        wr(`SSC_OFS_DOWN_MS, 32'h1);
        drive(16'h3, 16'h0, 32'sh5DD);
        wait_speed(32'sh5DC, 1400);
        check("alarm", {31'h0, status_flags.overspeed}, 32'h1);
        drive(16'h3, 16'h0, 32'sh5DC);
        repeat (3) @(posedge clk);
        check("alarm", {31'h0, status_flags.overspeed}, 32'h0);
        wr(`SSC_OFS_MAX, 32'hBB8);
        wait_speed(32'sh8FC, 900);
        wr(`SSC_OFS_MAX, 32'h5DC);
        wait_speed(32'sh5DC, 900);
        drive(16'h1, 16'h0, 32'sh0);
        wait_speed(32'sh12C, 1300);
        wr(`SSC_OFS_ADD_SRC, 32'h400);
        wait_speed(32'sh258, 400);
        wr(`SSC_OFS_ADD_SRC, 32'h0);
        wr(`SSC_OFS_CMD_SRC, 32'h23EE0);
        drive(16'h1, 16'h800, 32'sh0);
        wait_speed(-32'sh12C, 1000);
        drive(16'h9, 16'h800, 32'sh0);
        wait_speed(32'sh0, 400);
        drive(16'h1, 16'h0, 32'sh0);
        wait_speed(32'sh12C, 700);
        wr(`SSC_OFS_CMD_SRC, 32'h400020);
        wait_speed(32'sh0, 400);
        wr(`SSC_OFS_CMD_SRC, 32'h20);
        wr(`SSC_OFS_MIN, 32'h1F4);
        wait_speed(32'sh1F4, 600);
        wr(`SSC_OFS_MIN, 32'h0);
        drive(16'h0, 16'h0, 32'sh0);
        wait_speed(32'sh0, 600);
        drive(16'h1, 16'h0, 32'sh0);
        wait_speed(32'sh12C, 400);
        wr(`SSC_OFS_CMD_SRC, 32'h10000020);
        wait_speed(32'sh0, 8);
        wr(`SSC_OFS_MODE, 32'h0);
        wr(`SSC_OFS_SEL_SRC, 32'h8E2860);
        for (int i = 0; i < 16; i++) wr(`SSC_OFS_FIXED_BASE + 12'(4 * i), 32'(16 * i - 100));
        wr(`SSC_OFS_CMD_SRC, 32'h10);
        for (int i = 15; i >= 0; i--) begin
            drive(16'(i), 16'h0, 32'sh0);
            wait_speed(32'(16 * i - 100), 300);
        end
        rd_chk(`SSC_OFS_RAMP, 32'hFFFFFF9C);
        check("flags", {25'h0, status_flags}, 32'h42);
        final_report();
    end
endmodule
